//--- tx_descriptor_ring_engine.sv
// Transmit descriptor ring engine: fetch, send, write back
// Contract
// - Word 0 of an entry is the buffer byte count that sizes the transfer.
// - Word 1 is the low 16 buffer address bits, joined with the high bits of word 2.
// - Ownership is cleared only after the frame is done and status is written.
// - After a buffer is sent its status is written into that same entry.
// - Bit 14 of word 2 is the OR of the six error bits 15 to 10 of word 3.
// - Bit 13 of word 2 flags a destination match with this station.
// - Bit 12 of word 2 flags more than one retry, up to sixteen.
// - Bit 11 of word 2 flags exactly one collision retry.
// - Bit 10 of word 2 flags that transmission had to wait for the medium.
// - Bits 1 to 0 of word 2 are the high address bits and bits 7 to 2 are zero.
// - A frame with a buffer length error in any of its entries is not sent.
// - A host bus timeout on a buffer read sets bit 14 of word 3 and stops the frame.
`default_nettype none
`include "txr_map.svh"
module tx_descriptor_ring_engine (
  input  wire logic        mclk,             // System clock
  input  wire logic        rstn,             // Synchronous reset, active low
  input  wire logic        ring_enable,      // Allow ring processing
  input  wire logic [17:0] tx_ring_base,     // Ring base byte address
  input  wire logic [7:0]  ring_entries,     // Entries in ring, nonzero
  input  wire logic        poll,             // Host handed new entries
  input  wire logic        pad_enable,       // Short frames padded
  input  wire logic        crc_disable,      // Host supplies CRC
  output logic             mem_req,          // Memory request
  output logic             mem_we,           // Memory write
  output logic      [17:0] mem_addr,         // Memory byte address, word aligned
  output logic      [15:0] mem_wdata,        // Memory write data
  input  wire logic        mem_ack,          // Memory done pulse
  input  wire logic        mem_timeout,      // Memory timeout pulse
  input  wire logic [15:0] mem_rdata,        // Memory read data
  output logic             tx_valid,         // Byte offered to medium
  output logic      [7:0]  tx_data,          // Byte
  output logic             tx_sof,           // First byte of frame
  output logic             tx_eof,           // Last byte of frame
  input  wire logic        tx_ready,         // Medium takes byte
  output logic             tx_abort,         // Drop frame pulse
  input  wire logic        mac_done,         // Medium finished pulse
  input  wire logic [4:0]  mac_retries,      // Retries used
  input  wire logic        mac_deferred,     // Waited for medium
  input  wire logic        mac_match,        // Station match
  input  wire logic        mac_underflow,    // Underflow
  input  wire logic        mac_late_col,     // Late collision
  input  wire logic        mac_carrier_loss, // Carrier lost
  input  wire logic        mac_retry_limit,  // Retry limit hit
  output logic             ring_waiting,     // Stopped at unowned entry
  output logic      [7:0]  ring_index        // Index of frame head entry
);
  txr_pkg::state_t state_q, state_d;
  logic [7:0]  first_q, first_d;
  logic [3:0]  nseg_q, nseg_d, k_q, k_d;
  logic [15:0] off_q, off_d, sent_q, sent_d;
  logic [16:0] total_q, total_d;
  logic        buffer_length_error_q, buffer_length_error_d, host_bus_timeout_error_q, host_bus_timeout_error_d, abort_q, abort_d;
  logic [7:0]  byte_q, byte_d;
  logic [1:0]  cflg_q, cflg_d;
  logic [1:0]  chi_q, chi_d;
  logic [4:0]  ret_q, ret_d;
  logic [5:0]  mb_q, mb_d;
  // Per-buffer memory of one frame
  logic [15:0] seg_len [0:7];
  logic [17:0] seg_adr [0:7];
  logic [1:0]  seg_flg [0:7];
  logic        seg_we;
  logic [17:0] seg_adr_wv;
  logic [3:0]  ek;
  logic [8:0]  esum;
  logic [7:0]  eidx;
  logic [17:0] ebase, baddr;
  logic        done;
  logic [16:0] min_len, max_len;
  logic [15:0] w_ctl, w_sts;

  // Entry address of buffer ek of the current frame, ring order
  always_comb begin
    ek = (state_q == txr_pkg::S_WR6 || state_q == txr_pkg::S_WR4) ? k_q : nseg_q;
    esum = {1'b0, first_q} + {5'h00, ek};
    if (esum >= {1'b0, ring_entries}) begin
      esum = esum - {1'b0, ring_entries};
    end
    eidx = esum[7:0];
    ebase = tx_ring_base + {7'h00, eidx, 3'h0};
    baddr = seg_adr[k_q[2:0]] + {2'h0, off_q};
  end

  // Length limits from mode
  always_comb begin
    min_len = crc_disable ? `TXR_MIN_NOCRC : (pad_enable ? `TXR_MIN_PAD : `TXR_MIN_NOPAD);
    max_len = crc_disable ? `TXR_MAX_NOCRC : `TXR_MAX_CRC;
  end

  tx_status_compose u_compose (
    .buffer_length_error     (buffer_length_error_q),
    .host_bus_timeout_error     (host_bus_timeout_error_q),
    .retries  (ret_q),
    .deferred (mb_q[5]),
    .match    (mb_q[4]),
    .underflow_error     (mb_q[3]),
    .late_collision_error     (mb_q[2]),
    .carrier_loss_error     (mb_q[1]),
    .retry_limit_error     (mb_q[0]),
    .first_buffer_flag      (seg_flg[k_q[2:0]][1]),
    .last_buffer_flag      (seg_flg[k_q[2:0]][0]),
    .adr_hi   (seg_adr[k_q[2:0]][17:16]),
    .word_ctl (w_ctl),
    .word_sts (w_sts)
  );

  // Memory port driven from state
  always_comb begin
    mem_req = 1'b0;
    mem_we = 1'b0;
    mem_addr = 18'h00000;
    mem_wdata = 16'h0000;
    case (state_q)
      txr_pkg::S_CTL: begin
        mem_req = 1'b1;
        mem_addr = ebase + `TXR_W_CTL;
      end
      txr_pkg::S_LEN: begin
        mem_req = 1'b1;
        mem_addr = ebase + `TXR_W_LEN;
      end
      txr_pkg::S_ADR: begin
        mem_req = 1'b1;
        mem_addr = ebase + `TXR_W_ADR;
      end
      txr_pkg::S_RDB: begin
        mem_req = off_q != seg_len[k_q[2:0]];
        mem_addr = {baddr[17:1], 1'b0};
      end
      txr_pkg::S_WR6: begin
        mem_req = 1'b1;
        mem_we = 1'b1;
        mem_addr = ebase + `TXR_W_STS;
        mem_wdata = w_sts;
      end
      txr_pkg::S_WR4: begin
        mem_req = 1'b1;
        mem_we = 1'b1;
        mem_addr = ebase + `TXR_W_CTL;
        mem_wdata = w_ctl;
      end
      default: begin
        mem_req = 1'b0;
      end
    endcase
  end

  // Byte stream and status outputs
  always_comb begin
    tx_valid = state_q == txr_pkg::S_SEND;
    tx_data = byte_q;
    tx_sof = tx_valid && sent_q == 16'h0000;
    tx_eof = tx_valid && {1'b0, sent_q} + 17'h00001 == total_q;
    tx_abort = abort_q;
    ring_waiting = state_q == txr_pkg::S_WAIT;
    ring_index = first_q;
  end

  // Ring walk, stream and write-back sequencing
  always_comb begin
    done = mem_ack | mem_timeout;
    state_d = state_q;
    first_d = first_q;
    nseg_d = nseg_q;
    k_d = k_q;
    off_d = off_q;
    sent_d = sent_q;
    total_d = total_q;
    buffer_length_error_d = buffer_length_error_q;
    host_bus_timeout_error_d = host_bus_timeout_error_q;
    abort_d = 1'b0;
    byte_d = byte_q;
    cflg_d = cflg_q;
    chi_d = chi_q;
    ret_d = ret_q;
    mb_d = mb_q;
    seg_we = 1'b0;
    seg_adr_wv = {chi_q, mem_rdata};
    case (state_q)
      txr_pkg::S_IDLE: begin
        if (ring_enable) begin
          state_d = txr_pkg::S_CTL;
        end
      end
      txr_pkg::S_WAIT: begin
        if (poll) begin
          state_d = txr_pkg::S_CTL;
        end
      end
      txr_pkg::S_CTL: begin
        if (nseg_q == 4'h0) begin
          buffer_length_error_d = 1'b0;
          host_bus_timeout_error_d = 1'b0;
          ret_d = 5'h00;
          mb_d = 6'h00;
          total_d = 17'h00000;
        end
        if (mem_timeout) begin
          state_d = nseg_q == 4'h0 ? txr_pkg::S_WAIT : txr_pkg::S_WR6;
          buffer_length_error_d = nseg_q != 4'h0;
          k_d = 4'h0;
        end else if (mem_ack) begin
          cflg_d = {mem_rdata[`TXR_B_STF], mem_rdata[`TXR_B_ENF]};
          chi_d = mem_rdata[1:0];
          if (nseg_q == 4'h0) begin
            state_d = mem_rdata[`TXR_B_OWN] ? txr_pkg::S_LEN : txr_pkg::S_WAIT;
          end else if (!mem_rdata[`TXR_B_OWN] || mem_rdata[`TXR_B_STF] ||
                       nseg_q == `TXR_SEG_MAX) begin
            buffer_length_error_d = 1'b1;
            k_d = 4'h0;
            state_d = txr_pkg::S_WR6;
          end else begin
            state_d = txr_pkg::S_LEN;
          end
        end
      end
      txr_pkg::S_LEN: begin
        if (done) begin
          total_d = total_q + {1'b0, mem_rdata};
          state_d = txr_pkg::S_ADR;
        end
      end
      txr_pkg::S_ADR: begin
        if (done) begin
          seg_we = 1'b1;
          nseg_d = nseg_q + 4'h1;
          state_d = cflg_q[0] ? txr_pkg::S_CHECK : txr_pkg::S_CTL;
        end
      end
      txr_pkg::S_CHECK: begin
        k_d = 4'h0;
        off_d = 16'h0000;
        sent_d = 16'h0000;
        if (total_q < min_len || total_q > max_len) begin
          buffer_length_error_d = 1'b1;
          state_d = txr_pkg::S_WR6;
        end else begin
          state_d = txr_pkg::S_RDB;
        end
      end
      txr_pkg::S_RDB: begin
        if (off_q == seg_len[k_q[2:0]]) begin
          off_d = 16'h0000;
          k_d = k_q + 4'h1;
          if (k_q + 4'h1 == nseg_q) begin
            k_d = 4'h0;
            state_d = txr_pkg::S_MAC;
          end
        end else if (mem_timeout) begin
          host_bus_timeout_error_d = 1'b1;
          abort_d = 1'b1;
          k_d = 4'h0;
          state_d = txr_pkg::S_WR6;
        end else if (mem_ack) begin
          byte_d = baddr[0] ? mem_rdata[15:8] : mem_rdata[7:0];
          state_d = txr_pkg::S_SEND;
        end
      end
      txr_pkg::S_SEND: begin
        if (tx_ready) begin
          off_d = off_q + 16'h0001;
          sent_d = sent_q + 16'h0001;
          state_d = txr_pkg::S_RDB;
        end
      end
      txr_pkg::S_MAC: begin
        if (mac_done) begin
          ret_d = mac_retries;
          mb_d = {mac_deferred, mac_match, mac_underflow, mac_late_col,
                  mac_carrier_loss, mac_retry_limit};
          state_d = txr_pkg::S_WR6;
        end
      end
      txr_pkg::S_WR6: begin
        if (done) begin
          state_d = txr_pkg::S_WR4;
        end
      end
      txr_pkg::S_WR4: begin
        if (done) begin
          k_d = k_q + 4'h1;
          state_d = txr_pkg::S_WR6;
          if (k_q + 4'h1 == nseg_q) begin
            first_d = eidx + 8'h01 == ring_entries ? 8'h00 : eidx + 8'h01;
            nseg_d = 4'h0;
            k_d = 4'h0;
            state_d = ring_enable ? txr_pkg::S_CTL : txr_pkg::S_IDLE;
          end
        end
      end
      default: begin
        state_d = txr_pkg::S_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_q <= txr_pkg::S_IDLE;
      first_q <= 8'h00;
      nseg_q <= 4'h0;
      k_q <= 4'h0;
      off_q <= 16'h0000;
      sent_q <= 16'h0000;
      total_q <= 17'h00000;
      buffer_length_error_q <= 1'b0;
      host_bus_timeout_error_q <= 1'b0;
      abort_q <= 1'b0;
      byte_q <= 8'h00;
      cflg_q <= 2'h0;
      chi_q <= 2'h0;
      ret_q <= 5'h00;
      mb_q <= 6'h00;
    end else begin
      state_q <= state_d;
      first_q <= first_d;
      nseg_q <= nseg_d;
      k_q <= k_d;
      off_q <= off_d;
      sent_q <= sent_d;
      total_q <= total_d;
      buffer_length_error_q <= buffer_length_error_d;
      host_bus_timeout_error_q <= host_bus_timeout_error_d;
      abort_q <= abort_d;
      byte_q <= byte_d;
      cflg_q <= cflg_d;
      chi_q <= chi_d;
      ret_q <= ret_d;
      mb_q <= mb_d;
    end
  end

  // Buffer memory write, length latched one step earlier
  logic [15:0] len_hold_q;
  always_ff @(posedge mclk) begin
    if (state_q == txr_pkg::S_LEN && done) begin
      len_hold_q <= mem_rdata;
    end
    if (seg_we) begin
      seg_len[nseg_q[2:0]] <= len_hold_q;
      seg_adr[nseg_q[2:0]] <= seg_adr_wv;
      seg_flg[nseg_q[2:0]] <= cflg_q;
    end
  end

  // Checks
  a_status_first: assert property (@(posedge mclk) disable iff (!rstn)
    state_q == txr_pkg::S_WR4 && $past(state_q) != txr_pkg::S_WR4
      |-> $past(state_q) == txr_pkg::S_WR6) else $error("owner cleared before status");
  a_owner_cleared: assert property (@(posedge mclk) disable iff (!rstn)
    state_q == txr_pkg::S_WR4 |-> mem_we && !mem_wdata[15]) else $error("owner not cleared");
  a_err_summary: assert property (@(posedge mclk) disable iff (!rstn)
    state_q == txr_pkg::S_WR4 |-> mem_wdata[14] == (buffer_length_error_q | host_bus_timeout_error_q | (|mb_q[3:0])))
    else $error("error summary wrong");
  a_mbz_bits: assert property (@(posedge mclk) disable iff (!rstn)
    state_q == txr_pkg::S_WR4 |-> mem_wdata[7:2] == 6'h00) else $error("reserved bits set");
  a_one_retry: assert property (@(posedge mclk) disable iff (!rstn)
    state_q == txr_pkg::S_WR4 |-> mem_wdata[11] == (ret_q == 5'h01) &&
      mem_wdata[12] == (ret_q > 5'h01)) else $error("retry flags wrong");
  a_buffer_length_error_no_send: assert property (@(posedge mclk) disable iff (!rstn)
    buffer_length_error_q |-> !tx_valid) else $error("frame sent with length error");
  a_host_bus_timeout_error_abort: assert property (@(posedge mclk) disable iff (!rstn)
    state_q == txr_pkg::S_RDB && mem_req && mem_timeout
      |=> tx_abort && host_bus_timeout_error_q && state_q == txr_pkg::S_WR6 ##1 !tx_valid)
    else $error("timeout did not stop frame");
  a_stop_unowned: assert property (@(posedge mclk) disable iff (!rstn)
    state_q == txr_pkg::S_CTL && nseg_q == 4'h0 && mem_ack && !mem_rdata[15]
      |=> ring_waiting [*2] or (ring_waiting ##1 state_q == txr_pkg::S_CTL))
    else $error("fetch passed unowned entry");
  a_status_after: assert property (@(posedge mclk) disable iff (!rstn)
    state_q == txr_pkg::S_MAC && mac_done |=> mem_req && mem_we && mem_addr[2:1] == 2'h3)
    else $error("status not written");
  c_frame_sent: cover property (@(posedge mclk) disable iff (!rstn) tx_eof && tx_ready);
  c_buffer_length_error_wb: cover property (@(posedge mclk) disable iff (!rstn)
    buffer_length_error_q && state_q == txr_pkg::S_WR4);
  c_ring_wait: cover property (@(posedge mclk) disable iff (!rstn) ring_waiting && poll);
endmodule : tx_descriptor_ring_engine
`default_nettype wire

//--- txr_map.svh
// Offsets, field positions, limits for the transmit descriptor ring engine
`ifndef TXR_MAP_SVH
`define TXR_MAP_SVH
// Byte offsets of the four words inside one 8-byte ring entry
`define TXR_W_LEN      18'h00000
`define TXR_W_ADR      18'h00002
`define TXR_W_CTL      18'h00004
`define TXR_W_STS      18'h00006
// Control word bit positions
`define TXR_B_OWN      15
`define TXR_B_ERROR_SUMMARY_FLAG     14
`define TXR_B_MATCH    13
`define TXR_B_MORE     12
`define TXR_B_ONE      11
`define TXR_B_DEF      10
`define TXR_B_STF      9
`define TXR_B_ENF      8
// Status word bit positions
`define TXR_B_BUFFER_LENGTH_ERROR     15
`define TXR_B_HOST_BUS_TIMEOUT_ERROR     14
`define TXR_B_UNDERFLOW_ERROR     13
`define TXR_B_LATE_COLLISION_ERROR     12
`define TXR_B_CARRIER_LOSS_ERROR     11
`define TXR_B_RETRY_LIMIT_ERROR     10
// Frame length limits in bytes
`define TXR_MIN_PAD    17'h0000e
`define TXR_MIN_NOPAD  17'h0003c
`define TXR_MIN_NOCRC  17'h00040
`define TXR_MAX_CRC    17'h005ea
`define TXR_MAX_NOCRC  17'h005ee
// Most buffers one frame may span
`define TXR_SEG_MAX    4'h8
`endif

//--- txr_pkg.sv
// Types shared by the transmit descriptor ring engine
`default_nettype none
package txr_pkg;
  typedef enum logic [3:0] {
    S_IDLE, S_CTL, S_LEN, S_ADR, S_CHECK, S_RDB, S_SEND, S_MAC, S_WR6, S_WR4, S_WAIT
  } state_t;
endpackage : txr_pkg
`default_nettype wire

//--- tx_status_compose.sv
// Builds the control and status words written back into a ring entry
`default_nettype none
`include "txr_map.svh"
module tx_status_compose (
  input  wire logic        buffer_length_error,      // Buffer length error
  input  wire logic        host_bus_timeout_error,      // Host bus timeout error
  input  wire logic [4:0]  retries,   // Retries used by the medium
  input  wire logic        deferred,  // Waited for medium
  input  wire logic        match,     // Destination matched station
  input  wire logic        underflow_error,      // Underflow error
  input  wire logic        late_collision_error,      // Late collision error
  input  wire logic        carrier_loss_error,      // Carrier loss error
  input  wire logic        retry_limit_error,      // Retry limit error
  input  wire logic        first_buffer_flag,       // First buffer flag kept
  input  wire logic        last_buffer_flag,       // Last buffer flag kept
  input  wire logic [1:0]  adr_hi,    // High address bits kept
  output logic      [15:0] word_ctl,  // Control word, owner cleared
  output logic      [15:0] word_sts   // Status word
);
  // Status word: six error bits, rest zero
  always_comb begin
    word_sts = 16'h0000;
    word_sts[`TXR_B_BUFFER_LENGTH_ERROR] = buffer_length_error;
    word_sts[`TXR_B_HOST_BUS_TIMEOUT_ERROR] = host_bus_timeout_error;
    word_sts[`TXR_B_UNDERFLOW_ERROR] = underflow_error;
    word_sts[`TXR_B_LATE_COLLISION_ERROR] = late_collision_error;
    word_sts[`TXR_B_CARRIER_LOSS_ERROR] = carrier_loss_error;
    word_sts[`TXR_B_RETRY_LIMIT_ERROR] = retry_limit_error;
  end
  // Control word, owner bit returned to host
  always_comb begin
    word_ctl = 16'h0000;
    word_ctl[`TXR_B_OWN]   = 1'b0;
    word_ctl[`TXR_B_ERROR_SUMMARY_FLAG]  = buffer_length_error | host_bus_timeout_error | underflow_error | late_collision_error | carrier_loss_error | retry_limit_error;
    word_ctl[`TXR_B_MATCH] = match;
    word_ctl[`TXR_B_MORE]  = retries > 5'h01;
    word_ctl[`TXR_B_ONE]   = retries == 5'h01;
    word_ctl[`TXR_B_DEF]   = deferred;
    word_ctl[`TXR_B_STF]   = first_buffer_flag;
    word_ctl[`TXR_B_ENF]   = last_buffer_flag;
    word_ctl[1:0]          = adr_hi;
  end
endmodule : tx_status_compose
`default_nettype wire

//--- host_memory_model.sv
// Host memory holding ring entries and buffers, answering word accesses
`default_nettype none
module host_memory_model (
  input  wire logic        mclk,        // System clock
  input  wire logic        rstn,        // Synchronous reset, active low
  input  wire logic        mem_req,     // Access pending
  input  wire logic        mem_we,      // Write access
  input  wire logic [17:0] mem_addr,    // Byte address
  input  wire logic [15:0] mem_wdata,   // Write data
  input  wire logic [3:0]  ack_wait,    // Wait cycles before answer
  input  wire logic        to_en,       // Fail one address
  input  wire logic [17:0] to_addr,     // Address that times out
  output logic             mem_ack,     // Done pulse
  output logic             mem_timeout, // Timeout pulse
  output logic      [15:0] mem_rdata    // Read data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [0:511];
  logic [3:0]  cnt_q;
  // Read data valid only with the done pulse, inverted otherwise
  assign mem_rdata = mem_ack ? mem[mem_addr[9:1]] : ~mem[mem_addr[9:1]];
  // One answer per access after ack_wait cycles
  always @(posedge mclk) begin
    mem_ack     <= 1'b0;
    mem_timeout <= 1'b0;
    if (!rstn) begin
      cnt_q <= 4'h0;
    end else if (mem_req && !mem_ack && !mem_timeout) begin
      if (cnt_q == ack_wait) begin
        cnt_q <= 4'h0;
        if (to_en && mem_addr == to_addr) begin
          mem_timeout <= 1'b1;
        end else begin
          mem_ack <= 1'b1;
          if (mem_we) begin
            mem[mem_addr[9:1]] <= mem_wdata;
          end
        end
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule : host_memory_model
`default_nettype wire

//--- tb.sv
// Self-checking testbench for the transmit descriptor ring engine
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk, rstn, ring_enable, poll, pad_enable, crc_disable;
  logic        mem_req, mem_we, mem_ack, mem_timeout, to_en, slow;
  logic        tx_valid, tx_sof, tx_eof, tx_abort, ring_waiting;
  logic        mac_deferred, mac_match, mac_late_col, mac_carrier_loss;
  logic        tx_ready = 1'b0;
  logic        mac_done = 1'b0;
  logic [17:0] mem_addr, to_addr;
  logic [15:0] mem_wdata, mem_rdata;
  logic [7:0]  tx_data, ring_index;
  logic [4:0]  mac_retries;
  logic [3:0]  ack_wait;
  logic [7:0]  got[$];
  int          miscompares, cmp_count, abort_seen, eof_seen, sof_bad, done_wait;

  tx_descriptor_ring_engine i_tx_descriptor_ring_engine (
    .mclk(mclk), .rstn(rstn), .ring_enable(ring_enable), .tx_ring_base(18'h00100),
    .ring_entries(8'h04), .poll(poll), .pad_enable(pad_enable), .crc_disable(crc_disable),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_timeout(mem_timeout), .mem_rdata(mem_rdata),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_sof(tx_sof), .tx_eof(tx_eof),
    .tx_ready(tx_ready), .tx_abort(tx_abort), .mac_done(mac_done), .mac_retries(mac_retries),
    .mac_deferred(mac_deferred), .mac_match(mac_match), .mac_underflow(1'b0),
    .mac_late_col(mac_late_col), .mac_carrier_loss(mac_carrier_loss),
    .mac_retry_limit(1'b0), .ring_waiting(ring_waiting), .ring_index(ring_index));

  host_memory_model i_host_memory_model (
    .mclk(mclk), .rstn(rstn), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .ack_wait(ack_wait), .to_en(to_en), .to_addr(to_addr),
    .mem_ack(mem_ack), .mem_timeout(mem_timeout), .mem_rdata(mem_rdata));

  // Clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Medium side: collect bytes, watch framing, count aborts
  always @(posedge mclk) begin
    if (tx_abort === 1'b1) abort_seen++;
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      got.push_back(tx_data);
      if (tx_sof !== (got.size() == 1)) sof_bad++;
      if (tx_eof === 1'b1) begin
        eof_seen++;
        done_wait = 3;
      end
    end
  end

  // Medium side: ready pattern and finish pulse off the sampling edge
  always @(negedge mclk) begin
    mac_done <= (done_wait == 1);
    if (done_wait != 0) done_wait--;
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end

  function automatic logic [7:0] exp_byte(input logic [17:0] a);
    return a[7:0] ^ 8'h3c;
  endfunction : exp_byte

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("Comparisons %0d, miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  // Host builds one entry, control word last so ownership comes last
  task automatic put_entry(input int i, input logic [15:0] len, input logic [17:0] adr,
                           input logic first_buffer_flag, input logic last_buffer_flag);
    int w;
    w = 128 + 4 * i;
    i_host_memory_model.mem[w]     = len;
    i_host_memory_model.mem[w + 1] = adr[15:0];
    i_host_memory_model.mem[w + 3] = 16'hffff;
    i_host_memory_model.mem[w + 2] = {1'b1, 5'h00, first_buffer_flag, last_buffer_flag, 6'h00, adr[17:16]};
  endtask : put_entry

  // Poll, then wait a bounded time for the entry to come back
  task automatic run_frame(input int i);
    int n;
    got.delete();
    abort_seen = 0;
    eof_seen = 0;
    sof_bad = 0;
    @(negedge mclk);
    poll = 1'b1;
    @(negedge mclk);
    poll = 1'b0;
    for (n = 0; n < 3000; n++) begin
      @(negedge mclk);
      if (i_host_memory_model.mem[130 + 4 * i][15] === 1'b0) break;
    end
    if (n == 3000) begin
      miscompares++;
      end_of_test();
    end
  endtask : run_frame

  task automatic check_bytes(input int first, input logic [17:0] adr, input int len);
    for (int k = 0; k < len; k++) begin
      check({8'h00, got[first + k]}, {8'h00, exp_byte(adr + 18'(k))});
    end
  endtask : check_bytes

  task automatic check_words(input int i, input logic [15:0] ctl, input logic [15:0] sts);
    check(i_host_memory_model.mem[130 + 4 * i], ctl);
    check(i_host_memory_model.mem[131 + 4 * i], sts);
  endtask : check_words

  // Single buffer, one retry, deferred, station match, high address bits
  task automatic sc_basic();
    pad_enable = 1'b1;
    mac_retries = 5'h01;
    mac_deferred = 1'b1;
    mac_match = 1'b1;
    put_entry(0, 16'h000e, 18'h10200, 1'b1, 1'b1);
    run_frame(0);
    check(16'(got.size()), 16'h000e);
    check_bytes(0, 18'h10200, 14);
    check(16'(eof_seen), 16'h0001);
    check_words(0, 16'h2f01, 16'h0000);
  endtask : sc_basic

  // Two chained buffers, odd start, slow memory and medium, sixteen retries
  task automatic sc_chain();
    pad_enable = 1'b0;
    ack_wait = 4'h3;
    slow = 1'b1;
    mac_retries = 5'h10;
    mac_deferred = 1'b0;
    mac_match = 1'b0;
    mac_late_col = 1'b1;
    mac_carrier_loss = 1'b1;
    put_entry(2, 16'h001f, 18'h00281, 1'b0, 1'b1);
    put_entry(1, 16'h001e, 18'h00240, 1'b1, 1'b0);
    run_frame(2);
    check(16'(got.size()), 16'h003d);
    check_bytes(0, 18'h00240, 30);
    check_bytes(30, 18'h00281, 31);
    check(16'(sof_bad), 16'h0000);
    check({15'h0000, i_host_memory_model.mem[134][15]}, 16'h0000);
    check_words(2, 16'h5100, 16'h1800);
    mac_late_col = 1'b0;
    mac_carrier_loss = 1'b0;
    ack_wait = 4'h0;
    slow = 1'b0;
  endtask : sc_chain

  // One byte below the unpadded minimum: nothing sent, length error
  task automatic sc_length();
    put_entry(3, 16'h003b, 18'h002c0, 1'b1, 1'b1);
    run_frame(3);
    check(16'(got.size()), 16'h0000);
    check_words(3, 16'h4300, 16'h8000);
  endtask : sc_length

  // Buffer read times out after the ring wraps to entry 0
  task automatic sc_timeout();
    pad_enable = 1'b1;
    to_en = 1'b1;
    to_addr = 18'h00304;
    put_entry(0, 16'h0014, 18'h00300, 1'b1, 1'b1);
    run_frame(0);
    check(16'(abort_seen), 16'h0001);
    check(16'(eof_seen), 16'h0000);
    check_words(0, 16'h4300, 16'h4000);
    to_en = 1'b0;
  endtask : sc_timeout

  // Stopped at an unowned entry, resumes only on poll
  task automatic sc_resume();
    pad_enable = 1'b0;
    crc_disable = 1'b1;
    mac_retries = 5'h00;
    // Write-back just finished: let the engine fetch entry 1 and stop there
    repeat (6) @(negedge mclk);
    check({15'h0000, ring_waiting}, 16'h0001);
    check({8'h00, ring_index}, 16'h0001);
    got.delete();
    put_entry(1, 16'h0040, 18'h00340, 1'b1, 1'b1);
    repeat (30) @(negedge mclk);
    check(16'(got.size()), 16'h0000);
    run_frame(1);
    check(16'(got.size()), 16'h0040);
    check_bytes(0, 18'h00340, 64);
    check_words(1, 16'h0300, 16'h0000);
  endtask : sc_resume

  // Main sequence
  initial begin
    rstn = 1'b0;
    ring_enable = 1'b0;
    poll = 1'b0;
    pad_enable = 1'b0;
    crc_disable = 1'b0;
    mac_retries = 5'h00;
    mac_deferred = 1'b0;
    mac_match = 1'b0;
    mac_late_col = 1'b0;
    mac_carrier_loss = 1'b0;
    ack_wait = 4'h0;
    to_en = 1'b0;
    to_addr = 18'h00000;
    slow = 1'b0;
    for (int w = 0; w < 512; w++) begin
      i_host_memory_model.mem[w] = {exp_byte(18'(2 * w + 1)), exp_byte(18'(2 * w))};
    end
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    check({4'h0, mem_req, tx_valid, tx_abort, ring_waiting, ring_index}, 16'h0000);
    rstn = 1'b1;
    ring_enable = 1'b1;
    repeat (10) @(negedge mclk);
    check({15'h0000, ring_waiting}, 16'h0001);
    sc_basic();
    sc_chain();
    sc_length();
    sc_timeout();
    sc_resume();
    end_of_test();
  end
endmodule : tb
`default_nettype wire
